// [logic/crs_core.sv]
// Purpose: Executes return, rotate, sleep and literal-subtract words
// Assumes: Words are issued by an APB write to the command register
// Notes: File space is flip-flops; the watchdog runs from clk
// Notes: The bus stalls while a word executes, so software never races execution
// How it works
// - A return word pops the stack and loads the popped value into the program counter.
// - A return takes two execute cycles and leaves every status flag alone.
// - Rotate-left moves bit n to n+1, bit 7 to carry, old carry to bit 0.
// - A destination bit of 0 writes the rotate result to the accumulator, 1 to the file.
// - Rotate-right moves bit n to n-1, bit 0 to carry, old carry to bit 7.
// - The sleep word clears the watchdog counter and its prescaler.
// - The sleep word clears the power-down bit and sets the timeout bit only.
// - The subtract word puts literal minus accumulator into the accumulator.
// - Subtract carry and digit carry are 0 when the accumulator part exceeds the literal.
//
// Chosen here: the register offsets and the APB interface to the registers.
`default_nettype none
module crs_core #(
    parameter int PC_W = 15,
    parameter int STACK_DEPTH = 16,
    parameter int WDT_W = 8,
    parameter int PRE_W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sleep_entered
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    typedef struct packed {
        crs_pkg::crs_state_t state;
        logic [15:0] instr;
        logic [7:0] accum;
        logic [4:0] status;
        logic [PC_W-1:0] program_counter;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [SP_W-1:0] sp;
        logic [WDT_W-1:0] watchdog_counter;
        logic [PRE_W-1:0] prescaler;
        logic [6:0] faddr;
        logic [127:0][7:0] file;
        logic sleeping;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } crs_regs_t;

    crs_regs_t s_q;
    crs_regs_t s_d;

    // Register read mux; unmapped offsets read zero
    function automatic logic [32:0] read_reg(input crs_regs_t s, input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0;
        case (a)
            crs_pkg::OFF_CMD: r[15:0] = s.instr;
            crs_pkg::OFF_ACC: r[7:0] = s.accum;
            crs_pkg::OFF_STATUS: r[4:0] = s.status;
            crs_pkg::OFF_PC: r[PC_W-1:0] = s.program_counter;
            crs_pkg::OFF_STACK: r[PC_W-1:0] = s.stack[s.sp - SP_W'(1)];
            crs_pkg::OFF_WDOG: r[31:0] = {16'h0, 8'(s.prescaler), 8'(s.watchdog_counter)};
            crs_pkg::OFF_FADDR: r[6:0] = s.faddr;
            crs_pkg::OFF_FDATA: r[7:0] = s.file[s.faddr];
            crs_pkg::OFF_CTRL: r[1:0] = {s.sleeping, s.state != crs_pkg::CRS_IDLE};
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    // Rotate through carry; returns {carry_out, result}
    function automatic logic [8:0] rotate(input logic [7:0] v, input logic c, input logic left);
        if (left)
        begin
            return {v[7], v[6:0], c};
        end
        return {v[0], c, v[7:1]};
    endfunction

    // Instruction decode of the held word
    logic exec;
    logic is_ret;
    logic is_rotl;
    logic is_rotr;
    logic is_sleep;
    logic is_sub;
    logic [7:0] operand;
    assign exec = s_q.state == crs_pkg::CRS_EXEC;
    assign is_ret = (s_q.instr & crs_pkg::RET_MASK) == crs_pkg::RET_MATCH;
    assign is_rotl = (s_q.instr & crs_pkg::ROT_MASK) == crs_pkg::ROTL_MATCH;
    assign is_rotr = (s_q.instr & crs_pkg::ROT_MASK) == crs_pkg::ROTR_MATCH;
    assign is_sleep = s_q.instr == crs_pkg::SLEEP_OP;
    assign is_sub = (s_q.instr & crs_pkg::SUB_MASK) == crs_pkg::SUB_MATCH;
    assign operand = s_q.file[s_q.instr[6:0]];

    // Next-state logic: APB slave, watchdog, then execution
    always_comb
    begin
        logic [32:0] rd;
        logic [8:0] rot;
        logic [8:0] diff;
        logic [7:0] k;
        logic acc_ph;
        rd = 33'h0;
        rot = 9'h0;
        diff = 9'h0;
        k = s_q.instr[7:0];
        acc_ph = psel && penable;
        s_d = s_q;
        s_d.ready = 1'b0;
        // Answer one cycle into the access phase, stalling while busy
        if (acc_ph && !s_q.ready && s_q.state == crs_pkg::CRS_IDLE)
        begin
            rd = read_reg(s_q, paddr);
            s_d.ready = 1'b1;
            s_d.err = rd[32];
            s_d.rdata = pwrite ? 32'h0 : rd[31:0];
        end
        // Writes take effect at the edge that samples pready high
        if (acc_ph && s_q.ready && pwrite)
        begin
            case (paddr)
                crs_pkg::OFF_CMD:
                begin
                    s_d.instr = pwdata[15:0];
                    s_d.state = crs_pkg::CRS_EXEC;
                    s_d.sleeping = 1'b0;
                end
                crs_pkg::OFF_ACC: s_d.accum = pwdata[7:0];
                crs_pkg::OFF_STATUS: s_d.status = pwdata[4:0];
                crs_pkg::OFF_PC: s_d.program_counter = pwdata[PC_W-1:0];
                crs_pkg::OFF_STACK:
                begin
                    s_d.stack[s_q.sp] = pwdata[PC_W-1:0];
                    s_d.sp = s_q.sp + SP_W'(1);
                end
                crs_pkg::OFF_FADDR: s_d.faddr = pwdata[6:0];
                crs_pkg::OFF_FDATA: s_d.file[s_q.faddr] = pwdata[7:0];
                default: s_d.err = s_q.err;
            endcase
        end
        // Watchdog prescaler and counter run freely
        s_d.prescaler = s_q.prescaler + PRE_W'(1);
        if (&s_q.prescaler)
        begin
            s_d.watchdog_counter = s_q.watchdog_counter + WDT_W'(1);
        end
        // Execution; the word's own effect wins over anything above
        case (s_q.state)
            crs_pkg::CRS_EXEC:
            begin
                s_d.state = crs_pkg::CRS_IDLE;
                s_d.program_counter = s_q.program_counter + PC_W'(1);
                if (is_ret)
                begin
                    s_d.sp = s_q.sp - SP_W'(1);
                    s_d.state = crs_pkg::CRS_RET2;
                    s_d.program_counter = s_q.program_counter;
                end
                else if (is_rotl || is_rotr)
                begin
                    rot = rotate(operand, s_q.status[crs_pkg::ST_C], is_rotl);
                    s_d.status[crs_pkg::ST_C] = rot[8];
                    if (s_q.instr[crs_pkg::DEST_BIT])
                    begin
                        s_d.file[s_q.instr[6:0]] = rot[7:0];
                    end
                    else
                    begin
                        s_d.accum = rot[7:0];
                    end
                end
                else if (is_sleep)
                begin
                    s_d.watchdog_counter = '0;
                    s_d.prescaler = '0;
                    s_d.status[crs_pkg::ST_TO] = 1'b1;
                    s_d.status[crs_pkg::ST_PD] = 1'b0;
                    s_d.sleeping = 1'b1;
                end
                else if (is_sub)
                begin
                    diff = {1'b0, k} - {1'b0, s_q.accum};
                    s_d.accum = diff[7:0];
                    s_d.status[crs_pkg::ST_C] = s_q.accum <= k;
                    s_d.status[crs_pkg::ST_DC] = s_q.accum[3:0] <= k[3:0];
                    s_d.status[crs_pkg::ST_Z] = diff[7:0] == 8'h00;
                end
            end
            crs_pkg::CRS_RET2:
            begin
                s_d.program_counter = s_q.stack[s_q.sp];
                s_d.state = crs_pkg::CRS_IDLE;
            end
            crs_pkg::CRS_IDLE:
            begin
                // Keep whatever the bus decided, so a command write starts execution
            end
            default: s_d.state = crs_pkg::CRS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.status <= crs_pkg::STATUS_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign sleep_entered = s_q.sleeping;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Return: pop then load the popped value
    ret_pc_load_a: assert property (exec && is_ret |=>
        s_q.sp == $past(s_q.sp) - SP_W'(1) ##1
        s_q.program_counter == $past(s_q.stack[s_q.sp]))
        else $error("return did not load popped value");
    ret_two_cyc_a: assert property (exec && is_ret |=>
        s_q.state == crs_pkg::CRS_RET2 && $stable(s_q.status) ##1
        s_q.state == crs_pkg::CRS_IDLE && $stable(s_q.status))
        else $error("return timing or flags wrong");
    rotl_to_acc_a: assert property (exec && is_rotl && !s_q.instr[9] |=>
        s_q.accum == {$past(operand[6:0]), $past(s_q.status[0])}
        && s_q.status[0] == $past(operand[7]))
        else $error("rotate left result wrong");
    rot_to_file_a: assert property ((exec && (is_rotl || is_rotr) && s_q.instr[9]) |=>
        $stable(s_q.accum) && $stable(s_q.status[4:1])
        && s_q.status[0] == ($past(is_rotl) ? $past(operand[7]) : $past(operand[0]))
        && s_q.file[$past(s_q.instr[6:0])] == ($past(is_rotl)
        ? {$past(operand[6:0]), $past(s_q.status[0])}
        : {$past(s_q.status[0]), $past(operand[7:1])}))
        else $error("rotate to file wrong");
    rotr_to_acc_a: assert property (exec && is_rotr && !s_q.instr[9] |=>
        s_q.accum == {$past(s_q.status[0]), $past(operand[7:1])}
        && s_q.status[0] == $past(operand[0]))
        else $error("rotate right result wrong");

    // Rotates touch only carry; a rotate into the accumulator leaves the file
    rot_flags_a: assert property (exec && (is_rotl || is_rotr) |=>
        s_q.status[4:1] == $past(s_q.status[4:1]))
        else $error("rotate changed a flag other than carry");
    rot_acc_keep_a: assert property (exec && (is_rotl || is_rotr) && !s_q.instr[9] |=>
        s_q.file[$past(s_q.instr[6:0])] == $past(operand))
        else $error("rotate into accumulator changed the file");

    // The bus stays stalled for both cycles of a return
    ret_stall_a: assert property (exec && is_ret |=> !pready ##1 !pready)
        else $error("bus answered during a return");
    sleep_wdt_a: assert property (exec && is_sleep |=>
        s_q.watchdog_counter == '0 && s_q.prescaler == '0 ##1 s_q.prescaler == PRE_W'(1))
        else $error("sleep did not clear watchdog");
    sleep_status_a: assert property (exec && is_sleep |=>
        s_q.status[4:3] == 2'b10 && s_q.status[2:0] == $past(s_q.status[2:0]))
        else $error("sleep status bits wrong");
    sub_result_a: assert property (exec && is_sub |=>
        s_q.accum == 8'($past(s_q.instr[7:0]) - $past(s_q.accum)))
        else $error("subtract result wrong");
    sub_carry_a: assert property (exec && is_sub |=>
        s_q.status[0] == ($past(s_q.accum) <= $past(s_q.instr[7:0]))
        && s_q.status[1] == ($past(s_q.accum[3:0]) <= $past(s_q.instr[3:0])))
        else $error("subtract carry flags wrong");
    sub_zero_a: assert property (exec && is_sub |=>
        s_q.status[2] == (s_q.accum == 8'h00))
        else $error("subtract zero flag wrong");


    // Sleep raises the sleep flag and leaves the accumulator alone
    sleep_flag_a: assert property (exec && is_sleep |=>
        sleep_entered && $stable(s_q.accum))
        else $error("sleep flag or accumulator wrong");

    // Subtract only moves the arithmetic flags
    sub_keep_a: assert property (exec && is_sub |=>
        s_q.status[4:3] == $past(s_q.status[4:3]))
        else $error("subtract changed a power status bit");

    // Every word but a return steps the program counter by one
    pc_step_a: assert property (exec && !is_ret |=>
        s_q.program_counter == $past(s_q.program_counter) + PC_W'(1))
        else $error("program counter did not step");

    // Main scenarios reached
    ret_seen_c: cover property (exec && is_ret ##3 pready);
    sleep_seen_c: cover property (exec && is_sleep);
    sub_zero_c: cover property (exec && is_sub ##1 s_q.status[2]);
    rotl_file_c: cover property (exec && is_rotl && s_q.instr[9]);
    rotr_acc_c: cover property (exec && is_rotr && !s_q.instr[9]);
endmodule
`default_nettype wire

// [logic/crs_pkg.sv]
// Purpose: Constants for the return/rotate/sleep/subtract core
// Assumes: 16-bit instruction words, APB register access
// Notes: Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package crs_pkg;
    // Register offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_STACK = 8'h10;
    localparam logic [7:0] OFF_WDOG = 8'h14;
    localparam logic [7:0] OFF_FADDR = 8'h18;
    localparam logic [7:0] OFF_FDATA = 8'h1c;
    localparam logic [7:0] OFF_CTRL = 8'h20;
    // Status field positions and reset value
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam logic [4:0] STATUS_RST = 5'h18;
    // Instruction decode
    localparam logic [15:0] RET_MASK = 16'hfffe;
    localparam logic [15:0] RET_MATCH = 16'h0012;
    localparam logic [15:0] ROT_MASK = 16'hfc00;
    localparam logic [15:0] ROTL_MATCH = 16'h3400;
    localparam logic [15:0] ROTR_MATCH = 16'h3000;
    localparam logic [15:0] SLEEP_OP = 16'h0063;
    localparam logic [15:0] SUB_MASK = 16'hff00;
    localparam logic [15:0] SUB_MATCH = 16'h3c00;
    localparam int DEST_BIT = 9;
    // Sequencer states
    typedef enum logic [1:0] {CRS_IDLE, CRS_EXEC, CRS_RET2} crs_state_t;
endpackage
`default_nettype wire

// [sim/tb_cpu_return_rotate_sleep_sub.sv]
// Purpose: Self-checking bench for the return/rotate/sleep/subtract core
// Assumes: APB slave answers one cycle into the access phase when idle
// Notes: Reads note the expected word in a queue; a monitor compares on pready
`default_nettype none
module tb_cpu_return_rotate_sleep_sub;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_entered;
    logic [32:0] exp_q[$];
    logic [32:0] mask_q[$];
    int errors = 0;
    int cmp_count = 0;
    logic [7:0] w, k, v, r, res;
    logic [6:0] f;
    logic [4:0] st;
    logic [14:0] p1, p2;
    logic c;

    crs_core crs_core_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_entered(sleep_entered));

    // Clock at 50 MHz
    always #10 clk = ~clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Note the expected {error, data} under a mask, then read
    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [32:0] m = {33{1'b1}});
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    // Monitor: compare each read answer with the oldest note
    always @(posedge clk)
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata} & mask_q.pop_front(), exp_q.pop_front());

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h0cbf79e0));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(crs_pkg::OFF_STATUS, {28'h0, crs_pkg::STATUS_RST});
        rd(8'h24, {1'b1, 32'h0});
        // Subtract: boundaries first, then random operands
        for (int i = 0; i < 8; i++)
        begin
            w = (i == 0) ? 8'h00 : (i == 1) ? 8'h5a : (i == 2) ? 8'h0f : 8'($urandom);
            k = (i == 0) ? 8'hff : (i == 1) ? 8'h5a : (i == 2) ? 8'h10 : 8'($urandom);
            st = 5'($urandom);
            wr(crs_pkg::OFF_ACC, {24'h0, w});
            wr(crs_pkg::OFF_STATUS, {27'h0, st});
            wr(crs_pkg::OFF_CMD, {16'h0, crs_pkg::SUB_MATCH | {8'h0, k}});
            res = k - w;
            rd(crs_pkg::OFF_ACC, {25'h0, res});
            rd(crs_pkg::OFF_STATUS, {28'h0, st[4:3], res == 8'h00, w[3:0] <= k[3:0], w <= k});
        end
        // Rotate both ways to both destinations
        for (int j = 0; j < 4; j++)
        begin
            f = 7'($urandom);
            v = 8'($urandom);
            w = 8'($urandom);
            st = 5'($urandom);
            wr(crs_pkg::OFF_FADDR, {25'h0, f});
            wr(crs_pkg::OFF_FDATA, {24'h0, v});
            wr(crs_pkg::OFF_ACC, {24'h0, w});
            wr(crs_pkg::OFF_STATUS, {27'h0, st});
            wr(crs_pkg::OFF_CMD, {16'h0, (j[0] ? crs_pkg::ROTL_MATCH : crs_pkg::ROTR_MATCH)
                | (16'(j[1]) << crs_pkg::DEST_BIT) | {9'h0, f}});
            r = j[0] ? {v[6:0], st[0]} : {st[0], v[7:1]};
            c = j[0] ? v[7] : v[0];
            rd(crs_pkg::OFF_ACC, {25'h0, j[1] ? w : r});
            rd(crs_pkg::OFF_FDATA, {25'h0, j[1] ? r : v});
            rd(crs_pkg::OFF_STATUS, {28'h0, st[4:1], c});
        end
        // Two returns pop two pushed addresses
        p1 = 15'($urandom);
        p2 = 15'($urandom);
        st = 5'($urandom);
        wr(crs_pkg::OFF_STACK, {17'h0, p1});
        wr(crs_pkg::OFF_STACK, {17'h0, p2});
        wr(crs_pkg::OFF_STATUS, {27'h0, st});
        wr(crs_pkg::OFF_CMD, 32'h0000_0012);
        rd(crs_pkg::OFF_PC, {18'h0, p2});
        rd(crs_pkg::OFF_STACK, {18'h0, p1});
        wr(crs_pkg::OFF_CMD, 32'h0000_0013);
        rd(crs_pkg::OFF_PC, {18'h0, p1});
        rd(crs_pkg::OFF_STATUS, {28'h0, st});
        // Sleep after the watchdog has advanced
        st = {2'b01, 3'($urandom)};
        wr(crs_pkg::OFF_STATUS, {27'h0, st});
        repeat (600) @(posedge clk);
        wr(crs_pkg::OFF_CMD, 32'h0000_0063);
        rd(crs_pkg::OFF_WDOG, 33'h0, 33'h1_0000_f0ff);
        rd(crs_pkg::OFF_STATUS, {28'h0, 2'b10, st[2:0]});
        check({32'h0, sleep_entered}, 33'h1);
        rd(crs_pkg::OFF_CTRL, 33'h2);
        // A following no-op word clears the sleep indication
        wr(crs_pkg::OFF_CMD, 32'h0);
        rd(crs_pkg::OFF_CTRL, 33'h0);
        check({32'h0, sleep_entered}, 33'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
